// file: design/dadc_format.sv
// Output code formatter: two's complement word in, selected coding out.
// Assumes the input word is already offset corrected and saturated.
`timescale 1ns/10ps
module dadc_format #(
    parameter int W = 10
) (
    input  wire logic         fmt_twos,
    input  wire logic [W-1:0] word,
    output logic      [W-1:0] code
);
    import dadc_pkg::*;

    // ------------------------------------------------------------------
    // Coding
    // ------------------------------------------------------------------
    // Offset binary is two's complement with the sign bit turned round
    always_comb begin
        code = fmt_twos ? word : {~word[W-1], word[W-2:0]};
    end
endmodule

// file: design/dadc_offset.sv
// One channel's offset correction: averages a calibration run, subtracts it.
// Assumes strobe pulses once per sample clock period; raw is offset binary.
`timescale 1ns/10ps
module dadc_offset #(
    parameter int W = 10
) (
    input  wire logic   clk,
    input  wire logic   srst,
    dadc_chan_if.corr_end ch
);
    import dadc_pkg::*;

    typedef struct packed {
        logic                  busy;
        logic [DADC_CNT_W-1:0] cnt;
        logic [DADC_SUM_W-1:0] sum;
        logic [W-1:0]          offset;
    } dadc_ofs_t;

    dadc_ofs_t      st;
    dadc_ofs_t      next_st;
    logic [W-1:0]   sraw;
    logic [DADC_SUM_W-1:0] sext;
    logic [DADC_SUM_W-1:0] fsum;
    logic [W:0]     diff;

    // ------------------------------------------------------------------
    // Sequence and subtraction
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        sraw    = {~ch.raw[W-1], ch.raw[W-2:0]};
        sext    = {{(DADC_SUM_W-W){sraw[W-1]}}, sraw};
        fsum    = st.sum + sext;
        if (!st.busy && ch.start) begin
            next_st.busy = 1'b1;
            next_st.cnt  = '0;
            next_st.sum  = '0;
        end else if (st.busy && ch.strobe) begin
            // First two periods let the pipeline settle, the next 32 are summed
            if (st.cnt >= DADC_CAL_SKIP) begin
                next_st.sum = fsum;
            end
            if (st.cnt == DADC_CAL_LAST) begin
                next_st.busy   = 1'b0;
                next_st.offset = fsum[DADC_SUM_W-1:DADC_CAL_SHIFT];
            end
            next_st.cnt = st.cnt + 1'b1;
        end
        // Saturate so a large offset clips instead of wrapping
        diff = {sraw[W-1], sraw} - {st.offset[W-1], st.offset};
        if (diff[W] != diff[W-1]) begin
            ch.corr = {diff[W], {(W-1){~diff[W]}}};
        end else begin
            ch.corr = diff[W-1:0];
        end
        ch.busy   = st.busy;
        ch.offset = st.offset;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// file: design/dadc_top.sv
// Output control of a dual 10-bit sampling converter with an APB register port.
// Assumes SAMPLE_CLK is synchronous to CLK and far slower; I_CONV and Q_CONV
// carry the quantiser's offset binary result, valid at each sample instant.
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
module dadc_top #(
    parameter int W = dadc_pkg::DADC_W
) (
    input  wire logic                         CLK,
    input  wire logic                         SRST,
    input  wire logic                         SAMPLE_CLK,
    input  wire logic [W-1:0]                 I_CONV,
    input  wire logic [W-1:0]                 Q_CONV,
    input  wire logic                         PSEL,
    input  wire logic                         PENABLE,
    input  wire logic                         PWRITE,
    input  wire logic [dadc_pkg::DADC_AW-1:0] PADDR,
    input  wire logic [dadc_pkg::DADC_DW-1:0] PWDATA,
    output logic      [dadc_pkg::DADC_DW-1:0] PRDATA,
    output logic                              PREADY,
    output logic                              PSLVERR,
    output logic      [W-1:0]                 DATA_I,
    output logic      [W-1:0]                 DATA_Q,
    output logic                              IQ_IND,
    output logic                              ANA_GAIN,
    output logic                              ANA_STANDBY,
    output logic                              ANA_SLEEP
);
    import dadc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DADC_CTRL_W-1:0]          ctrl;
        logic                            prev_sclk;
        logic                            prev_trig;
        logic [DADC_PIPE-1:0][W-1:0]     pipe_i;
        logic [DADC_PIPE-1:0][W-1:0]     pipe_q;
        logic [W-1:0]                    data_i;
        logic [W-1:0]                    data_q;
        logic                            iq_ind;
        logic                            ana_gain;
        logic                            ana_standby;
        logic                            ana_sleep;
        logic [DADC_DW-1:0]              prdata;
        logic                            pready;
        logic                            pslverr;
    } dadc_top_t;

    dadc_top_t      st;
    dadc_top_t      next_st;

    dadc_pmode_t    pmode;
    logic           run;
    logic           bus_select;
    logic           format_select;
    logic           offset_correct_trigger;
    logic           sclk_fall;
    logic           sclk_rise;
    logic           cal_start;
    logic [W-1:0]   code_i;
    logic [W-1:0]   code_q;
    logic [DADC_DW-1:0] stat_word;
    logic [DADC_DW-1:0] offs_word;

    dadc_chan_if #(.W(W)) ch_i ();
    dadc_chan_if #(.W(W)) ch_q ();

    // ------------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------------
    assign bus_select             = st.ctrl[DADC_CTRL_BUS];
    assign format_select          = st.ctrl[DADC_CTRL_FMT];
    assign offset_correct_trigger = st.ctrl[DADC_CTRL_OCT];

    // Sleep is checked first so it wins when both requests are set
    always_comb begin
        if (st.ctrl[DADC_CTRL_SLP]) begin
            pmode = DADC_SLEEP;
        end else if (st.ctrl[DADC_CTRL_SBY]) begin
            pmode = DADC_STANDBY;
        end else begin
            pmode = DADC_RUN;
        end
    end

    assign run       = (pmode == DADC_RUN);
    assign sclk_fall = st.prev_sclk & ~SAMPLE_CLK;
    assign sclk_rise = ~st.prev_sclk & SAMPLE_CLK;
    // A trigger edge seen while not converting is dropped, not queued
    assign cal_start = offset_correct_trigger & ~st.prev_trig & run;

    // ------------------------------------------------------------------
    // Channel correctors and formatters
    // ------------------------------------------------------------------
    assign ch_i.strobe = sclk_fall & run;
    assign ch_q.strobe = sclk_fall & run;
    assign ch_i.start  = cal_start;
    assign ch_q.start  = cal_start;
    assign ch_i.raw    = I_CONV;
    assign ch_q.raw    = Q_CONV;

    dadc_offset #(.W(W)) u_ofs_i (
        .clk  (CLK),
        .srst (SRST),
        .ch   (ch_i.corr_end)
    );

    dadc_offset #(.W(W)) u_ofs_q (
        .clk  (CLK),
        .srst (SRST),
        .ch   (ch_q.corr_end)
    );

    dadc_format #(.W(W)) u_fmt_i (
        .fmt_twos (format_select),
        .word     (ch_i.corr),
        .code     (code_i)
    );

    dadc_format #(.W(W)) u_fmt_q (
        .fmt_twos (format_select),
        .word     (ch_q.corr),
        .code     (code_q)
    );

    // ------------------------------------------------------------------
    // Register read views
    // ------------------------------------------------------------------
    always_comb begin
        stat_word                                    = '0;
        stat_word[DADC_STAT_BSYI]                    = ch_i.busy;
        stat_word[DADC_STAT_BSYQ]                    = ch_q.busy;
        stat_word[DADC_STAT_MODE +: $bits(pmode)]    = pmode;
        stat_word[DADC_STAT_IQ]                      = st.iq_ind;
        offs_word                                    = '0;
        offs_word[W-1:0]                             = ch_i.offset;
        offs_word[DADC_OFFS_Q +: W]                  = ch_q.offset;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.prev_sclk = SAMPLE_CLK;
        next_st.prev_trig = offset_correct_trigger;

        // Analog front end controls follow the register one cycle later
        next_st.ana_gain    = st.ctrl[DADC_CTRL_GAIN];
        next_st.ana_standby = (pmode == DADC_STANDBY);
        next_st.ana_sleep   = (pmode == DADC_SLEEP);

        // Sampling: both channels shift in on the same falling edge
        if (sclk_fall && run) begin
            next_st.pipe_i = {st.pipe_i[DADC_PIPE-2:0], code_i};
            next_st.pipe_q = {st.pipe_q[DADC_PIPE-2:0], code_q};
        end

        // Output update; when not running data_i and iq_ind hold the last word, data_q too unless multiplexed mode clears it
        if (sclk_rise && run) begin
            next_st.data_i = st.pipe_i[DADC_TAP];
            next_st.data_q = st.pipe_q[DADC_TAP];
            next_st.iq_ind = 1'b1;
        end else if (sclk_fall && run) begin
            // Pre-shift tap holds the word sampled three falls ago
            if (!bus_select) begin
                next_st.data_i = st.pipe_q[DADC_TAP];
            end
            next_st.iq_ind = 1'b0;
        end
        // Q lines held low in every cycle of multiplexed mode
        if (!bus_select) begin
            next_st.data_q = '0;
        end

        // APB: ready is raised in the access phase of every transfer
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (PSEL && !PENABLE) begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            if (PWRITE) begin
                next_st.pslverr = (PADDR != DADC_ADDR_CTRL);
            end else begin
                case (PADDR)
                    DADC_ADDR_CTRL: begin
                        next_st.prdata = {{(DADC_DW-DADC_CTRL_W){1'b0}}, st.ctrl};
                    end
                    DADC_ADDR_STAT: begin
                        next_st.prdata = stat_word;
                    end
                    DADC_ADDR_OFFS: begin
                        next_st.prdata = offs_word;
                    end
                    default: begin
                        next_st.pslverr = 1'b1;
                    end
                endcase
            end
        end
        if (PSEL && PENABLE && st.pready && PWRITE && (PADDR == DADC_ADDR_CTRL)) begin
            next_st.ctrl = PWDATA[DADC_CTRL_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            st      <= '0;
            st.ctrl <= DADC_CTRL_RST;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every data line is a plain flop output: no high-impedance state exists
    assign DATA_I      = st.data_i;
    assign DATA_Q      = st.data_q;
    assign IQ_IND      = st.iq_ind;
    assign ANA_GAIN    = st.ana_gain;
    assign ANA_STANDBY = st.ana_standby;
    assign ANA_SLEEP   = st.ana_sleep;
    assign PRDATA      = st.prdata;
    assign PREADY      = st.pready;
    assign PSLVERR     = st.pslverr;
endmodule

// file: inc/dadc_chan_if.sv
// Link between the top block and one channel's offset corrector.
// Assumes both ends run on the same fabric clock.
`timescale 1ns/10ps
interface dadc_chan_if #(parameter int W = 10);
    logic         strobe;
    logic         start;
    logic [W-1:0] raw;
    logic [W-1:0] corr;
    logic [W-1:0] offset;
    logic         busy;

    modport ctrl (output strobe, output start, output raw, input corr, input offset, input busy);
    modport corr_end (input strobe, input start, input raw, output corr, output offset, output busy);
endinterface

// file: inc/dadc_pkg.sv
// Shared constants and types of the dual converter output control block.
// Assumes one fabric clock; the sample clock arrives as a synchronous level.
package dadc_pkg;

    // ------------------------------------------------------------------
    // Data path
    // ------------------------------------------------------------------
    localparam int          DADC_W         = 10;
    localparam int          DADC_PIPE      = 3;
    localparam int          DADC_TAP       = 2;

    // ------------------------------------------------------------------
    // Offset correction sequence
    // ------------------------------------------------------------------
    localparam int          DADC_CNT_W     = 6;
    localparam int          DADC_SUM_W     = 15;
    localparam int          DADC_CAL_SHIFT = 5;
    localparam logic [5:0]  DADC_CAL_SKIP  = 6'h02;
    localparam logic [5:0]  DADC_CAL_LAST  = 6'h21;

    // ------------------------------------------------------------------
    // APB register map
    // ------------------------------------------------------------------
    localparam int          DADC_AW        = 8;
    localparam int          DADC_DW        = 32;
    localparam logic [7:0]  DADC_ADDR_CTRL = 8'h00;
    localparam logic [7:0]  DADC_ADDR_STAT = 8'h04;
    localparam logic [7:0]  DADC_ADDR_OFFS = 8'h08;

    localparam int          DADC_CTRL_W    = 6;
    localparam logic [5:0]  DADC_CTRL_RST  = 6'h00;
    localparam int          DADC_CTRL_BUS  = 0;
    localparam int          DADC_CTRL_FMT  = 1;
    localparam int          DADC_CTRL_GAIN = 2;
    localparam int          DADC_CTRL_SBY  = 3;
    localparam int          DADC_CTRL_SLP  = 4;
    localparam int          DADC_CTRL_OCT  = 5;

    localparam int          DADC_STAT_BSYI = 0;
    localparam int          DADC_STAT_BSYQ = 1;
    localparam int          DADC_STAT_MODE = 2;
    localparam int          DADC_STAT_IQ   = 4;
    localparam int          DADC_OFFS_Q    = 16;

    // ------------------------------------------------------------------
    // Power modes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DADC_RUN,
        DADC_STANDBY,
        DADC_SLEEP
    } dadc_pmode_t;

endpackage

// file: verification/dadc_checker.sv
// Concurrent checks on the ports of dadc_top, attached by bind.
// Assumes CTRL changes only through APB writes seen on the port.
`timescale 1ns/10ps
module dadc_checker
    import dadc_pkg::*;
#(
    parameter int W = 10
) (
    input wire logic                         CLK,
    input wire logic                         SRST,
    input wire logic                         SAMPLE_CLK,
    input wire logic                         PSEL,
    input wire logic                         PENABLE,
    input wire logic                         PWRITE,
    input wire logic [dadc_pkg::DADC_AW-1:0] PADDR,
    input wire logic [dadc_pkg::DADC_DW-1:0] PWDATA,
    input wire logic                         PREADY,
    input wire logic                         PSLVERR,
    input wire logic [W-1:0]                 DATA_I,
    input wire logic [W-1:0]                 DATA_Q,
    input wire logic                         IQ_IND,
    input wire logic                         ANA_GAIN,
    input wire logic                         ANA_STANDBY,
    input wire logic                         ANA_SLEEP
);
    // ------------------------------------------------------------------
    // Control shadow; quiet counts edges since the last CTRL write
    // ------------------------------------------------------------------
    logic [5:0] ctrl_sh;
    logic [1:0] quiet;
    logic       wr_ctrl;

    assign wr_ctrl = PSEL && PENABLE && PREADY && PWRITE && (PADDR == DADC_ADDR_CTRL);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ctrl_sh <= DADC_CTRL_RST;
            quiet   <= 2'h0;
        end else begin
            ctrl_sh <= wr_ctrl ? PWDATA[5:0] : ctrl_sh;
            quiet   <= wr_ctrl ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence apb_setup;
        PSEL && !PENABLE;
    endsequence
    sequence low_power_twice;
        (ANA_STANDBY || ANA_SLEEP) ##1 (ANA_STANDBY || ANA_SLEEP);
    endsequence

    chk_ready_after_setup: assert property (apb_setup |=> PREADY)
        else $error("ready missing after setup");
    chk_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    chk_mux_q_low: assert property ((quiet == 2'h3 && !ctrl_sh[0]) |-> DATA_Q == '0)
        else $error("Q bus not low in mux mode");
    chk_gain_copy: assert property (ANA_GAIN == $past(ctrl_sh[2]))
        else $error("gain output wrong");
    chk_sleep_wins: assert property ((quiet == 2'h3) |->
        (ANA_SLEEP == ctrl_sh[4]) && (ANA_STANDBY == (ctrl_sh[3] && !ctrl_sh[4])))
        else $error("power mode outputs wrong");
    chk_hold_low_power: assert property (low_power_twice |-> $stable(DATA_I) && $stable(DATA_Q))
        else $error("outputs moved in low power");
    chk_iq_after_rise: assert property ($rose(IQ_IND) |-> $past(SAMPLE_CLK))
        else $error("I indicator not after rise");
    chk_iq_after_fall: assert property ($fell(IQ_IND) |-> !$past(SAMPLE_CLK))
        else $error("Q indicator not after fall");
    chk_par_on_rise: assert property ((quiet == 2'h3 && ctrl_sh[0] && $changed(DATA_I)) |->
        $past(SAMPLE_CLK))
        else $error("parallel update not after rise");
endmodule

bind dadc_top dadc_checker #(.W(W)) u_dadc_checker (.CLK(CLK), .SRST(SRST), .SAMPLE_CLK(SAMPLE_CLK),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .DATA_I(DATA_I), .DATA_Q(DATA_Q), .IQ_IND(IQ_IND), .ANA_GAIN(ANA_GAIN),
    .ANA_STANDBY(ANA_STANDBY), .ANA_SLEEP(ANA_SLEEP));

// file: verification/dadc_sample_src.sv
// Quantiser stand-in: a divided sample clock and constant I/Q codes.
// Assumes the bench sets i_val and q_val; they reach the pins after a rise.
`timescale 1ns/10ps
module dadc_sample_src #(
    parameter int HALF = 4
) (
    input  wire logic                         clk,
    input  wire logic [dadc_pkg::DADC_W-1:0]  i_val,
    input  wire logic [dadc_pkg::DADC_W-1:0]  q_val,
    output logic                              sample_clk,
    output logic      [dadc_pkg::DADC_W-1:0]  i_conv,
    output logic      [dadc_pkg::DADC_W-1:0]  q_conv
);
    import dadc_pkg::*;
    int cnt = 0;

    initial begin
        sample_clk = 1'b1;
        i_conv = '0;
        q_conv = '0;
    end

    always @(posedge clk) begin
        if (cnt == HALF - 1) begin
            cnt <= 0;
            sample_clk <= !sample_clk;
            // New codes only after a rise, so they are steady at the fall
            if (!sample_clk) begin
                i_conv <= i_val;
                q_conv <= q_val;
            end
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// file: verification/test_dadc_top.sv
// Self-checking bench for dadc_top: APB tasks and table driven tests.
// Assumes the checker is attached by bind from its own file.
`timescale 1ns/10ps
module test_dadc_top;
    import dadc_pkg::*;
    localparam logic [9:0] TBL [3] = '{10'h3FF, 10'h200, 10'h000};
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  data_i;
    logic [9:0]  data_q;
    logic [9:0]  i_val = 10'h200;
    logic [9:0]  q_val = 10'h200;
    logic [9:0]  i_conv;
    logic [9:0]  q_conv;
    logic        smp_clk;
    logic        iq_ind;
    logic        ana_gain;
    logic        ana_sby;
    logic        ana_slp;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          t0;

    dadc_top u_dadc_top (.CLK(clk), .SRST(srst), .SAMPLE_CLK(smp_clk), .I_CONV(i_conv), .Q_CONV(q_conv),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .DATA_I(data_i), .DATA_Q(data_q), .IQ_IND(iq_ind),
        .ANA_GAIN(ana_gain), .ANA_STANDBY(ana_sby), .ANA_SLEEP(ana_slp));
    dadc_sample_src u_dadc_sample_src (.clk(clk), .i_val(i_val), .q_val(q_val), .sample_clk(smp_clk),
        .i_conv(i_conv), .q_conv(q_conv));

    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    function automatic logic [9:0] code(input logic [9:0] s, input logic f);
        return f ? (s ^ 10'h200) : s;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check("pready", 32'h1, 32'(pready));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Waits long enough for the 2.5 to 3 period pipeline to flush
    task automatic set_in(input logic [9:0] i, input logic [9:0] q);
        @(posedge clk);
        i_val <= i;
        q_val <= q;
        repeat (48) @(posedge clk);
    endtask

    task automatic wait_iq(input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (iq_ind !== v && n < 40);
    endtask

    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, bad_count);
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        apb(0, DADC_ADDR_CTRL, 32'h0);
        check("ctrl reset", 32'h0, rd);
        apb(0, DADC_ADDR_OFFS, 32'h0);
        check("offs reset", 32'h0, rd);
        check("data_i reset", 32'h0, 32'(data_i));
        end_test("reset");
        for (int f = 0; f < 2; f++) begin
            for (int j = 0; j < 3; j++) begin
                apb(1, DADC_ADDR_CTRL, {29'h0, j == 1, f[0], 1'b1});
                set_in(TBL[j], TBL[2-j]);
                check("par i", 32'(code(TBL[j], f[0])), 32'(data_i));
                check("par q", 32'(code(TBL[2-j], f[0])), 32'(data_q));
                check("gain", 32'(j == 1), 32'(ana_gain));
            end
        end
        end_test("codes");
        apb(1, DADC_ADDR_CTRL, 32'h0);
        set_in(10'h100, 10'h300);
        wait_iq(1'b1);
        check("mux i word", 32'h100, 32'(data_i));
        wait_iq(1'b0);
        check("mux q word", 32'h300, 32'(data_i));
        check("mux q bus", 32'h0, 32'(data_q));
        end_test("mux");
        apb(1, DADC_ADDR_CTRL, 32'h1);
        set_in(10'h205, 10'h1FD);
        apb(1, DADC_ADDR_CTRL, 32'h21);
        t0 = cyc;
        apb(0, DADC_ADDR_STAT, 32'h0);
        check("cal busy", 32'h3, 32'(rd[1:0]));
        for (int n = 0; n < 200 && rd[1:0] !== 2'h0; n++) apb(0, DADC_ADDR_STAT, 32'h0);
        check("cal span", 32'h1, 32'((cyc - t0 >= 33 * 8) && (cyc - t0 <= 36 * 8)));
        apb(0, DADC_ADDR_OFFS, 32'h0);
        check("offsets", 32'h03FD0005, rd);
        set_in(10'h205, 10'h1FD);
        check("corr i", 32'h200, 32'(data_i));
        check("corr q", 32'h200, 32'(data_q));
        set_in(10'h3FF, 10'h000);
        check("range i", 32'h3FA, 32'(data_i));
        check("range q", 32'h003, 32'(data_q));
        end_test("calibration");
        apb(1, DADC_ADDR_CTRL, 32'h9);
        apb(0, DADC_ADDR_STAT, 32'h0);
        check("standby mode", 32'h1, 32'(rd[3:2]));
        set_in(10'h100, 10'h300);
        check("standby hold", 32'h3FA, 32'(data_i));
        check("standby pin", 32'h1, 32'(ana_sby));
        apb(1, DADC_ADDR_CTRL, 32'h19);
        apb(0, DADC_ADDR_STAT, 32'h0);
        check("sleep mode", 32'h2, 32'(rd[3:2]));
        set_in(10'h100, 10'h300);
        check("sleep pins", 32'h2, 32'({ana_slp, ana_sby}));
        check("sleep hold", 32'h003, 32'(data_q));
        apb(1, DADC_ADDR_CTRL, 32'h1);
        set_in(10'h100, 10'h300);
        check("resume i", 32'h0FB, 32'(data_i));
        check("resume q", 32'h303, 32'(data_q));
        end_test("power");
        apb(0, 8'h0C, 32'h0);
        check("unmapped", 32'h1, {rd[30:0], err});
        apb(1, DADC_ADDR_STAT, 32'hF);
        check("ro write", 32'h1, 32'(err));
        apb(0, DADC_ADDR_CTRL, 32'h0);
        check("ctrl kept", 32'h1, rd);
        end_test("refusals");
        report_and_stop();
    end
endmodule
